// ### design/lfi_pkg.sv
// lfi_pkg: constants and carrier types for the led fault interrupt enable and
// supply fault status register block.
// assumes: one 100 MHz system clock; registers are reached through the
// register port of the serial bus slave that sits in front of this block.
package lfi_pkg;

    // register port geometry
    localparam int ADDR_W = 8;   // register offset width
    localparam int DATA_W = 16;  // register data width

    // register offsets
    localparam logic [ADDR_W-1:0] OFS_ENABLES = 8'h0c;  // led_fault_irq_enables
    localparam logic [ADDR_W-1:0] OFS_SUPPLY  = 8'h0e;  // supply_fault_flags

    // reset images
    localparam logic [DATA_W-1:0] ENABLES_RESET = 16'h00aa;
    localparam logic [DATA_W-1:0] SUPPLY_RESET  = 16'h0000;
    localparam logic [7:0]        RSVD_RESET    = 8'h00;

    // enable register layout: four 2-bit fields, index k at bits 2k+1:2k
    localparam int N_ENABLES  = 4;
    localparam int FIELD_W    = 2;
    localparam int EN_GLOBAL  = 3;   // bits 7-6
    localparam int EN_TIMEOUT = 2;   // bits 5-4, serial bus timeout
    localparam int EN_BADSTR  = 1;   // bits 3-2, bad string configuration
    localparam int EN_LEDFLT  = 0;   // bits 1-0, led open or short
    localparam int RSVD_LSB   = 8;   // reserved byte 15-8
    localparam int RSVD_MSB   = 15;
    localparam logic [N_ENABLES-1:0] EN_RESET = 4'hf;

    // enable field encodings
    localparam logic [FIELD_W-1:0] RD_OFF = 2'h0;  // reads while disabled
    localparam logic [FIELD_W-1:0] RD_ON  = 2'h2;  // reads while enabled
    localparam logic [FIELD_W-1:0] WR_OFF = 2'h1;  // write to disable
    localparam logic [FIELD_W-1:0] WR_ON  = 2'h3;  // write to enable

    // supply fault layout: fault k has status at 2k+1 and clear at 2k
    // k: 7 crc, 6 sync loss, 5 pump, 4 pump cap, 3 overcurrent,
    //    2 core undervoltage, 1 input overvoltage, 0 input undervoltage
    localparam int N_SUPPLY = 8;

    // one register request from the serial bus slave
    typedef struct packed {
        logic              wr;     // one-cycle write strobe
        logic              rd;     // one-cycle read strobe
        logic [ADDR_W-1:0] addr;   // register offset
        logic [DATA_W-1:0] wdata;  // write data
    } lfi_reg_req_t;

    // led-side fault levels, already latched by their detectors
    typedef struct packed {
        logic timeout;     // serial bus timeout
        logic bad_string;  // invalid string configuration
        logic led_fault;   // led open, internal short, short to ground
    } lfi_led_faults_t;

endpackage : lfi_pkg

// ### design/lfi_sync.sv
// lfi_sync: two-flop synchroniser for a vector of unrelated levels.
// assumes: each bit is an independent level from outside the clock domain;
// no bit is sampled before the second stage.
`timescale 1ns/10ps
module lfi_sync #(
    parameter int WIDTH = 8  // number of levels
) (
    // clock and reset
    input  wire logic             clk_sys_i,
    input  wire logic             sys_rst_i,
    input  wire logic             ce_i,
    // levels
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    // an empty vector has nothing to carry; refused at elaboration
    if (WIDTH < 1) begin : g_bad_width
        $error("lfi_sync: WIDTH must be at least 1");
    end

    logic [WIDTH-1:0] stage1;       // metastable stage, read by stage2 only
    logic [WIDTH-1:0] stage2;       // settled stage
    logic [WIDTH-1:0] next_stage1;
    logic [WIDTH-1:0] next_stage2;

    // next values: shift only while the clock enable is high
    always_comb begin
        next_stage1 = ce_i ? async_i : stage1;
        next_stage2 = ce_i ? stage1  : stage2;
    end

    // registers
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            stage1 <= '0;
            stage2 <= '0;
        end else begin
            stage1 <= next_stage1;
            stage2 <= next_stage2;
        end
    end

    assign sync_o = stage2;

endmodule : lfi_sync

// ### design/lfi_regs.sv
// lfi_regs: led fault interrupt enables, supply fault flags, interrupt output.
// assumes: register requests come from the serial bus slave on the same clock;
// supply fault levels come from analog detectors and are synchronised here.
`timescale 1ns/10ps
module lfi_regs #(
    parameter int NUM_SUPPLY = lfi_pkg::N_SUPPLY  // supply fault count
) (
    // clock, reset, enable
    input  wire logic                         clk_sys_i,
    input  wire logic                         sys_rst_i,
    input  wire logic                         ce_i,
    // register port from the serial bus slave
    input  wire lfi_pkg::lfi_reg_req_t        reg_req_i,
    output logic      [lfi_pkg::DATA_W-1:0]   reg_rdata_o,
    // fault inputs
    input  wire logic [NUM_SUPPLY-1:0]        supply_fault_i,
    input  wire lfi_pkg::lfi_led_faults_t     led_faults_i,
    // interrupt to the pin driver
    output logic                              irq_o
);
    import lfi_pkg::*;

    // the register layout holds exactly eight pairs in sixteen bits; refused at elaboration
    if (NUM_SUPPLY != N_SUPPLY) begin : g_bad_count
        $error("lfi_regs: NUM_SUPPLY must be 8");
    end

    // state
    logic [N_ENABLES-1:0]  en_q;          // enabled state per field
    logic [7:0]            rsvd_q;        // reserved byte, plain storage
    logic [NUM_SUPPLY-1:0] flag_q;        // latched supply faults
    logic [DATA_W-1:0]     rdata_q;       // read data register
    logic                  irq_q;         // interrupt level
    logic [N_ENABLES-1:0]  next_en;
    logic [7:0]            next_rsvd;
    logic [NUM_SUPPLY-1:0] next_flag;
    logic [DATA_W-1:0]     next_rdata;
    logic                  next_irq;

    // decoded accesses
    logic                  wr_en_reg;     // write to the enable register
    logic                  wr_sup_reg;    // write to the supply register
    logic [NUM_SUPPLY-1:0] fault_sync;    // synchronised fault levels
    logic [DATA_W-1:0]     en_image;      // enable register read image
    logic [DATA_W-1:0]     sup_image;     // supply register read image
    logic [NUM_SUPPLY-1:0] ack_hit;       // status and clear both written
    logic [N_ENABLES-1:0]  led_src;       // led-side faults per enable field
    logic                  led_pending;   // an enabled led-side fault

    // detector outputs are asynchronous to the register clock
    lfi_sync #(
        .WIDTH (NUM_SUPPLY)
    ) u_sync (
        .clk_sys_i (clk_sys_i),
        .sys_rst_i (sys_rst_i),
        .ce_i      (ce_i),
        .async_i   (supply_fault_i),
        .sync_o    (fault_sync)
    );

    // address decode; unmapped writes are dropped
    assign wr_en_reg  = reg_req_i.wr && (reg_req_i.addr == OFS_ENABLES);
    assign wr_sup_reg = reg_req_i.wr && (reg_req_i.addr == OFS_SUPPLY);

    // led-side faults lined up with their enable fields; global has none
    assign led_src = {1'b0, led_faults_i.timeout, led_faults_i.bad_string,
                      led_faults_i.led_fault};

    // per field: read image and write decode
    genvar k;
    generate
        for (k = 0; k < N_ENABLES; k++) begin : g_en
            // enabled field reads 2h, disabled reads 0h, never the written code
            assign en_image[FIELD_W*k +: FIELD_W] = en_q[k] ? RD_ON : RD_OFF;
            always_comb begin
                next_en[k] = en_q[k];
                // only 1h and 3h act; 0h and 2h leave the state alone
                if (ce_i && wr_en_reg) begin
                    if (reg_req_i.wdata[FIELD_W*k +: FIELD_W] == WR_OFF) begin
                        next_en[k] = 1'b0;
                    end else if (reg_req_i.wdata[FIELD_W*k +: FIELD_W] == WR_ON) begin
                        next_en[k] = 1'b1;
                    end
                end
            end
        end
    endgenerate
    assign en_image[RSVD_MSB:RSVD_LSB] = rsvd_q;

    // per supply fault: read image, acknowledge and latch
    generate
        for (k = 0; k < NUM_SUPPLY; k++) begin : g_sup
            assign sup_image[2*k+1] = flag_q[k];
            // clear bits do not store: they only qualify an acknowledge
            assign sup_image[2*k]   = 1'b0;
            assign ack_hit[k] = wr_sup_reg && reg_req_i.wdata[2*k+1]
                                && reg_req_i.wdata[2*k];
            always_comb begin
                next_flag[k] = flag_q[k];
                if (ce_i) begin
                    // a fault still present wins over the acknowledge
                    if (fault_sync[k]) begin
                        next_flag[k] = 1'b1;
                    end else if (ack_hit[k]) begin
                        next_flag[k] = 1'b0;
                    end
                end
            end
        end
    endgenerate

    // reserved byte keeps whatever was written
    always_comb begin
        next_rsvd = rsvd_q;
        if (ce_i && wr_en_reg) begin
            next_rsvd = reg_req_i.wdata[RSVD_MSB:RSVD_LSB];
        end
    end

    // read data: loaded on a read strobe, zero for an unmapped offset
    always_comb begin
        next_rdata = rdata_q;
        if (ce_i && reg_req_i.rd) begin
            unique case (reg_req_i.addr)
                OFS_ENABLES: next_rdata = en_image;
                OFS_SUPPLY:  next_rdata = sup_image;
                default:     next_rdata = '0;
            endcase
        end
    end

    // interrupt: supply faults have no field here, so they count as enabled;
    // the level drops with the flag it came from, clearing the pin too
    assign led_pending = |(led_src & en_q);
    always_comb begin
        next_irq = irq_q;
        if (ce_i) begin
            next_irq = en_q[EN_GLOBAL] && (led_pending || (|flag_q));
        end
    end

    // registers: enable and reserved reset values come from the package; flags, read data and interrupt reset to zero
    always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            en_q    <= EN_RESET;
            rsvd_q  <= RSVD_RESET;
            flag_q  <= '0;
            rdata_q <= '0;
            irq_q   <= 1'b0;
        end else begin
            en_q    <= next_en;
            rsvd_q  <= next_rsvd;
            flag_q  <= next_flag;
            rdata_q <= next_rdata;
            irq_q   <= next_irq;
        end
    end

    assign reg_rdata_o = rdata_q;
    assign irq_o       = irq_q;

    // ------------------------------------------------------------------
    // checks
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (sys_rst_i);

    // a read of the enable register
    sequence s_read_en;
        ce_i && reg_req_i.rd && (reg_req_i.addr == OFS_ENABLES);
    endsequence

    // status and clear both written for the undervoltage fault, no fault seen
    sequence s_ack_uv;
        ce_i && wr_sup_reg && (reg_req_i.wdata[1:0] == 2'b11) && !fault_sync[0];
    endsequence

    property p_reset_image;
        $past(sys_rst_i) |-> (en_image == ENABLES_RESET) && (sup_image == SUPPLY_RESET)
                              && !irq_o && (reg_rdata_o == '0);
    endproperty
    a_reset_image: assert property (p_reset_image) else $error("reset image wrong");

    property p_rsvd_store;
        ce_i && wr_en_reg |=> rsvd_q == $past(reg_req_i.wdata[RSVD_MSB:RSVD_LSB]);
    endproperty
    a_rsvd_store: assert property (p_rsvd_store) else $error("reserved byte lost");

    property p_read_off;
        s_read_en ##0 !en_q[EN_BADSTR] |=> reg_rdata_o[3:2] == RD_OFF;
    endproperty
    a_read_off: assert property (p_read_off) else $error("disabled field misread");

    property p_read_on;
        s_read_en ##0 en_q[EN_LEDFLT] |=> reg_rdata_o[1:0] == RD_ON;
    endproperty
    a_read_on: assert property (p_read_on) else $error("enabled field misread");

    property p_write_off;
        ce_i && wr_en_reg && (reg_req_i.wdata[7:6] == WR_OFF) |=> !en_q[EN_GLOBAL];
    endproperty
    a_write_off: assert property (p_write_off) else $error("disable write ignored");

    property p_write_on;
        ce_i && wr_en_reg && (reg_req_i.wdata[5:4] == WR_ON) |=> en_q[EN_TIMEOUT];
    endproperty
    a_write_on: assert property (p_write_on) else $error("enable write ignored");

    property p_write_hold;
        ce_i && wr_en_reg && !reg_req_i.wdata[2] |=> $stable(en_q[EN_BADSTR]);
    endproperty
    a_write_hold: assert property (p_write_hold) else $error("0h or 2h changed field");

    property p_flag_set;
        ce_i && fault_sync[NUM_SUPPLY-1] |=> sup_image[15];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("fault not latched");

    property p_ack;
        s_ack_uv |=> !flag_q[0];
    endproperty
    a_ack: assert property (p_ack) else $error("acknowledge did not clear");

    property p_status_only;
        ce_i && wr_sup_reg && (reg_req_i.wdata[1:0] == 2'b10) && flag_q[0] |=> flag_q[0];
    endproperty
    a_status_only: assert property (p_status_only) else $error("flag cleared alone");

    property p_irq_gate;
        ce_i && !en_q[EN_GLOBAL] |=> !irq_o;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq without global enable");

    property p_irq_raise;
        ce_i && en_q[EN_GLOBAL] && (flag_q != '0) |=> irq_o;
    endproperty
    a_irq_raise: assert property (p_irq_raise) else $error("irq missing");

    // a write of 1h to the led fault field turns it off
    property p_led_off;
        ce_i && wr_en_reg && (reg_req_i.wdata[1:0] == WR_OFF) |=> !en_q[EN_LEDFLT];
    endproperty
    a_led_off: assert property (p_led_off) else $error("led field not disabled");

    // a write of 3h to the bad string field turns it on
    property p_badstr_on;
        ce_i && wr_en_reg && (reg_req_i.wdata[3:2] == WR_ON) |=> en_q[EN_BADSTR];
    endproperty
    a_badstr_on: assert property (p_badstr_on) else $error("string field not enabled");

    // an enabled serial timeout raises the interrupt one edge later
    property p_timeout_irq;
        ce_i && en_q[EN_GLOBAL] && en_q[EN_TIMEOUT] && led_faults_i.timeout |=> irq_o;
    endproperty
    a_timeout_irq: assert property (p_timeout_irq) else $error("timeout irq missing");

    // a masked bad string fault alone never reaches the pin
    property p_badstr_mask;
        ce_i && !en_q[EN_BADSTR] && (flag_q == '0) && !led_faults_i.timeout
            && !led_faults_i.led_fault |=> !irq_o;
    endproperty
    a_badstr_mask: assert property (p_badstr_mask) else $error("masked fault raised irq");

    // supply read: status bits show the flags, clear bits read zero
    property p_sup_read;
        ce_i && reg_req_i.rd && (reg_req_i.addr == OFS_SUPPLY)
            |=> (reg_rdata_o[15] == $past(flag_q[NUM_SUPPLY-1])) && !reg_rdata_o[0];
    endproperty
    a_sup_read: assert property (p_sup_read) else $error("supply read image wrong");

    // a read of any other offset returns zero
    property p_unmapped;
        ce_i && reg_req_i.rd && (reg_req_i.addr != OFS_ENABLES)
            && (reg_req_i.addr != OFS_SUPPLY) |=> reg_rdata_o == '0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");

    // a latched flag sticks until it is acknowledged
    property p_flag_hold;
        ce_i && flag_q[0] && !ack_hit[0] |=> flag_q[0];
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag dropped unasked");

    // no fault seen, no flag set
    property p_flag_quiet;
        ce_i && !flag_q[0] && !fault_sync[0] |=> !flag_q[0];
    endproperty
    a_flag_quiet: assert property (p_flag_quiet) else $error("flag set without fault");

    // the acknowledge, then a cycle with nothing else pending
    sequence s_ack_quiet;
        s_ack_uv ##1 (ce_i && (flag_q[NUM_SUPPLY-1:1] == '0) && !led_pending);
    endsequence

    // the acknowledge clears the pin as well as the status bit
    property p_ack_irq;
        s_ack_quiet |=> !irq_o;
    endproperty
    a_ack_irq: assert property (p_ack_irq) else $error("pin not cleared by ack");

    // a low clock enable freezes the stored state and the pin
    property p_frozen;
        !ce_i |=> $stable(en_q) && $stable(rsvd_q) && $stable(flag_q) && $stable(irq_o);
    endproperty
    a_frozen: assert property (p_frozen) else $error("state moved while frozen");

endmodule : lfi_regs

// ### verification/lfi_host_model.sv
// lfi_host_model: register-port master standing in for the serial bus host.
// assumes: requests launch 1 ns after a rising edge; one strobe per transfer.
`timescale 1ns/10ps
module lfi_host_model (
    // clock
    input  wire logic                         clk_sys_i,
    // register port
    output lfi_pkg::lfi_reg_req_t             reg_req_o,
    input  wire logic [lfi_pkg::DATA_W-1:0]   reg_rdata_i
);
    import lfi_pkg::*;

    int gap = 0;  // idle cycles before each request, models a slow host

    // idle strobes low; address and data are scrambled so stale values never match
    initial reg_req_o = '{wr: 1'b0, rd: 1'b0, addr: 8'hff, wdata: 16'hffff};

    // one write; fields get 1h or 3h to change state, 0h to leave them alone
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        repeat (gap) @(posedge clk_sys_i);
        @(posedge clk_sys_i);
        #1;
        reg_req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_sys_i);
        #1;
        reg_req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask : wr

    // one read; data is taken once the register has settled
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
        repeat (gap) @(posedge clk_sys_i);
        @(posedge clk_sys_i);
        #1;
        reg_req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge clk_sys_i);
        #1;
        reg_req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 16'hffff};
        @(posedge clk_sys_i);
        #1;
        d = reg_rdata_i;
    endtask : rd
endmodule : lfi_host_model

// ### verification/tb.sv
// tb: self-checking bench for the enable and supply fault register block.
// assumes: lfi_regs with eight supply faults; host model drives the register port.
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin err_total++; $display("[FAIL] %s expected %h seen %h", n, e, g); end end
module tb;
    import lfi_pkg::*;

    logic            clk_sys_i = 1'b0;  // 100 MHz system clock
    logic            sys_rst_i = 1'b1;  // held for two cycles at start
    logic            ce_i      = 1'b1;  // clock enable
    lfi_reg_req_t    reg_req;           // from host model
    logic [15:0]     rdata;             // read data
    logic [7:0]      supply    = 8'h00; // supply fault levels
    lfi_led_faults_t led       = '0;    // led-side fault levels
    logic            irq;               // interrupt level
    int              err_total  = 0;
    int              n_compared = 0;

    always #5 clk_sys_i = ~clk_sys_i;

    lfi_regs #(.NUM_SUPPLY(N_SUPPLY)) DUT (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
        .ce_i(ce_i), .reg_req_i(reg_req), .reg_rdata_o(rdata), .supply_fault_i(supply),
        .led_faults_i(led), .irq_o(irq));
    lfi_host_model host (.clk_sys_i(clk_sys_i), .reg_req_o(reg_req), .reg_rdata_i(rdata));

    // wait whole cycles, landing just after an edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask : cyc

    // read one register and compare
    task automatic chk_rd(input logic [7:0] a, input logic [15:0] e, input string n);
        logic [15:0] v;
        host.rd(a, v);
        `CHK(n, e, v)
    endtask : chk_rd

    task automatic chk_irq(input logic e);
        `CHK("irq", e, irq)
    endtask : chk_irq

    // each field: disable, no-change write, enable
    task automatic t_fields();
        for (int k = 0; k < N_ENABLES; k++) begin
            host.wr(OFS_ENABLES, 16'(WR_OFF) << (2 * k));
            chk_rd(OFS_ENABLES, ENABLES_RESET & ~(16'(RD_ON) << (2 * k)), "off");
            host.wr(OFS_ENABLES, 16'(RD_ON) << (2 * k));
            chk_rd(OFS_ENABLES, ENABLES_RESET & ~(16'(RD_ON) << (2 * k)), "keep");
            host.wr(OFS_ENABLES, 16'(WR_ON) << (2 * k));
            chk_rd(OFS_ENABLES, ENABLES_RESET, "on");
        end
    endtask : t_fields

    // reserved byte is storage; unmapped offset is ignored and reads zero
    task automatic t_reserved();
        host.wr(OFS_ENABLES, 16'h5a00);
        host.wr(8'h0d, 16'h0055);
        chk_rd(OFS_ENABLES, 16'h5aaa, "rsvd");
        chk_rd(8'h0d, 16'h0000, "unmapped");
        host.wr(OFS_ENABLES, 16'h0000);
        chk_rd(OFS_ENABLES, 16'h00aa, "rsvd0");
    endtask : t_reserved

    // every supply fault: latch, refused acks, then a proper ack
    task automatic t_supply();
        for (int k = 0; k < N_SUPPLY; k++) begin
            host.gap = k % 2;
            supply[k] = 1'b1;
            cyc(5);
            chk_rd(OFS_SUPPLY, 16'h0001 << (2 * k + 1), "flag");
            chk_irq(1'b1);
            host.wr(OFS_SUPPLY, 16'h0003 << (2 * k));
            chk_rd(OFS_SUPPLY, 16'h0001 << (2 * k + 1), "busy");
            supply[k] = 1'b0;
            cyc(4);
            host.wr(OFS_SUPPLY, 16'h0002 << (2 * k));
            host.wr(OFS_SUPPLY, 16'h0001 << (2 * k));
            chk_rd(OFS_SUPPLY, 16'h0001 << (2 * k + 1), "half");
            host.wr(OFS_SUPPLY, 16'h0003 << (2 * k));
            chk_rd(OFS_SUPPLY, 16'h0000, "clr");
            chk_irq(1'b0);
        end
        host.gap = 0;
    endtask : t_supply

    // led faults gated by their own field and by the global field
    task automatic t_led();
        for (int j = 0; j < 3; j++) begin
            led = lfi_led_faults_t'(3'(1 << j));
            cyc(4);
            chk_irq(1'b1);
            host.wr(OFS_ENABLES, 16'(WR_OFF) << (2 * j));
            cyc(3);
            chk_irq(1'b0);
            host.wr(OFS_ENABLES, 16'(WR_ON) << (2 * j));
            host.wr(OFS_ENABLES, 16'(WR_OFF) << 6);
            cyc(3);
            chk_irq(1'b0);
            host.wr(OFS_ENABLES, 16'(WR_ON) << 6);
            cyc(3);
            chk_irq(1'b1);
            led = '0;
            cyc(3);
            chk_irq(1'b0);
        end
    endtask : t_led

    // frozen clock enable, supply fault with global off, reset mid-run
    task automatic t_ce_reset();
        ce_i = 1'b0;
        host.wr(OFS_ENABLES, 16'h0040);
        ce_i = 1'b1;
        chk_rd(OFS_ENABLES, ENABLES_RESET, "ce");
        host.wr(OFS_ENABLES, 16'h0040);
        supply[0] = 1'b1;
        cyc(5);
        chk_irq(1'b0);
        chk_rd(OFS_SUPPLY, 16'h0002, "gflag");
        supply[0] = 1'b0;
        sys_rst_i = 1'b1;
        cyc(2);
        sys_rst_i = 1'b0;
        chk_rd(OFS_ENABLES, ENABLES_RESET, "rst");
        chk_rd(OFS_SUPPLY, SUPPLY_RESET, "rsts");
    endtask : t_ce_reset

    // verdict and end of run
    task automatic results();
        if (err_total == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : results

    // main sequence
    initial begin
        cyc(2);
        sys_rst_i = 1'b0;
        chk_irq(1'b0);
        chk_rd(OFS_ENABLES, ENABLES_RESET, "reset");
        chk_rd(OFS_SUPPLY, SUPPLY_RESET, "sreset");
        t_fields();
        t_reserved();
        t_supply();
        t_led();
        t_ce_reset();
        results();
    end

    // watchdog: the run needs a few hundred cycles at most
    initial begin
        #200000;
        err_total++;
        results();
    end
endmodule : tb
